// [rtl/aic_cfg.svh]
// Constants of the analog input conditioning block
// Functional notes
// RULE1: Offset limited to -900..+900, default zero
// RULE2: Voltage offset unit is about 10 mV
// RULE3: Current offset unit is about 20 uA
// RULE4: Gain 0.100..5.000 in thousandths, default 1.000
// RULE5: Types 0-3 voltage, odd types negate
// RULE6: Types 4,5 are 4-20 mA, loss faults
// RULE7: Types 6,7 are 0-20 mA, no loss check
// RULE8: Types 8,9 alarm, run on held reference
// RULE9: Type 10 alarm, use preset speed one
// RULE10: Type 12 gives start/stop, strip source only
// RULE11: Unipolar: add offset, clamp zero, gain, negate
// RULE12: 4-20 mA: remove 4 mA, clamp, gain, negate
// RULE13: Loss below 2 mA, clears at 4 mA
// RULE14: Type 11 negated 10; hold is 4-5 s old
// RULE15: Torque use bypasses offset and gain
`ifndef AIC_CFG_SVH
`define AIC_CFG_SVH
`define AIC_ADDR_OFS     8'h00
`define AIC_ADDR_GAIN    8'h04
`define AIC_ADDR_TYPE    8'h08
`define AIC_ADDR_PRESET  8'h0c
`define AIC_ADDR_CTRL    8'h10
`define AIC_ADDR_STAT    8'h14
`define AIC_ADDR_MASK    8'h18
`define AIC_ADDR_REF     8'h1c
`define AIC_ADDR_LIVE    8'h20
`define AIC_OFS_RST      11'h000
`define AIC_GAIN_RST     13'h3e8
`define AIC_TYPE_RST     4'h0
`define AIC_PRESET_RST   16'h0000
`define AIC_OFS_MAX      16'sh0384
`define AIC_OFS_MIN      16'shfc7c
`define AIC_GAIN_MIN     16'h0064
`define AIC_GAIN_MAX     16'h1388
`define AIC_GAIN_DIV     28'sh00003e8
`define AIC_LZ_OFS       14'sh00c8
`define AIC_LOSS_TH      12'sh064
`define AIC_RET_TH       12'sh0c8
`define AIC_RUN_ON_TH    16'sh0064
`define AIC_RUN_OFF_TH   16'sh0032
`define AIC_CTRL_SRC     0
`define AIC_CTRL_TRQ     1
`define AIC_ST_FAULT     0
`define AIC_ST_ALM_SET   1
`define AIC_ST_ALM_CLR   2
`define AIC_ST_START     3
`define AIC_ST_STOP      4
`define AIC_ST_CFG_ERR   5
`define AIC_ST_W         6
`define AIC_HIST_STEP_MS 1000
`define AIC_CLK_KHZ      25000
`define AIC_HIST_DEPTH   5
`endif

// [rtl/aic_loss.sv]
// Signal loss detector with 2 mA entry and 4 mA exit
`timescale 1ns/100ps
`include "aic_cfg.svh"
module aic_loss (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic signed [11:0] smp,
	input  wire logic               smp_vld,
	input  wire logic               en,
	output logic                    lost,
	output logic                    lost_rise,
	output logic                    lost_fall
);
	logic lost_reg;
	logic lost_next;
	logic rise_reg;
	logic fall_reg;

	always_comb begin
		lost_next = lost_reg;
		if (!en) begin
			lost_next = 1'b0; // [RULE7]
		end else if (smp_vld && !lost_reg && smp < `AIC_LOSS_TH) begin
			lost_next = 1'b1; // [RULE13]
		end else if (smp_vld && lost_reg && smp >= `AIC_RET_TH) begin
			lost_next = 1'b0; // [RULE13]
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			lost_reg <= 1'b0;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			lost_reg <= lost_next;
			rise_reg <= lost_next & ~lost_reg;
			fall_reg <= lost_reg & ~lost_next;
		end
	end

	assign lost      = lost_reg;
	assign lost_rise = rise_reg;
	assign lost_fall = fall_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_loss_set;
		en && smp_vld && smp < `AIC_LOSS_TH |=> lost;
	endproperty
	a_loss_set: assert property (p_loss_set) // [RULE13]
		else $error("loss not declared below 2 mA");

	property p_loss_stay;
		en && lost && smp_vld && smp < `AIC_RET_TH |=> lost && !lost_fall;
	endproperty
	a_loss_stay: assert property (p_loss_stay) // [RULE13]
		else $error("loss cleared below 4 mA");

	property p_no_en;
		!en |=> !lost;
	endproperty
	a_no_en: assert property (p_no_en) // [RULE7]
		else $error("loss flagged with detection off");
endmodule // aic_loss

// [rtl/aic_pkg.sv]
// Types shared by the analog input conditioning block
`include "aic_cfg.svh"
package aic_pkg;
	typedef enum logic [1:0] {
		AIC_KIND_BIP = 2'h0,
		AIC_KIND_UNI = 2'h1,
		AIC_KIND_LZ  = 2'h2
	} aic_kind_e;
	typedef enum logic {
		AIC_RUN_IDLE = 1'h0,
		AIC_RUN_ON   = 1'h1
	} aic_run_e;
	typedef logic [3:0] aic_type_t;
endpackage

// [rtl/aic_scale.sv]
// Offset, clamp, gain and negation of one sample
`timescale 1ns/100ps
`include "aic_cfg.svh"
module aic_scale import aic_pkg::*; (
	input  wire logic clk,
	input  wire logic srst,
	aic_scl_if.scaler sb
);
	logic signed [13:0] sum;
	logic signed [27:0] prod;
	logic signed [27:0] quo;
	logic signed [27:0] res_c;
	logic signed [15:0] res_reg;
	logic               vld_reg;

	// One count is 10 mV on voltage and 20 uA on current [RULE2] [RULE3]
	always_comb begin
		sum = 14'(sb.smp) + 14'(sb.ofs);
		if (sb.kind == AIC_KIND_LZ) begin
			sum = sum - `AIC_LZ_OFS; // [RULE12]
		end
		if (sb.kind != AIC_KIND_BIP && sum < 14'sh0000) begin
			sum = 14'sh0000; // [RULE11] [RULE12]
		end
		prod = 28'(sum) * $signed({15'h0000, sb.gain}); // [RULE4]
		quo = prod / `AIC_GAIN_DIV;
		res_c = sb.inv ? -quo : quo; // [RULE5] [RULE11]
		if (sb.bypass) begin
			res_c = 28'(sb.smp); // [RULE15]
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			res_reg <= 16'h0000;
			vld_reg <= 1'b0;
		end else begin
			vld_reg <= sb.smp_vld;
			if (sb.smp_vld) begin
				res_reg <= res_c[15:0];
			end
		end
	end

	assign sb.res     = res_reg;
	assign sb.res_vld = vld_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_clamp;
		sb.smp_vld && sb.kind == AIC_KIND_UNI && !sb.inv && !sb.bypass
		|=> sb.res >= 16'sh0000;
	endproperty
	a_clamp: assert property (p_clamp) // [RULE11]
		else $error("unipolar result below zero");

	property p_lz_neg;
		sb.smp_vld && sb.kind == AIC_KIND_LZ && sb.inv && !sb.bypass
		|=> sb.res <= 16'sh0000 && sb.res_vld;
	endproperty
	a_lz_neg: assert property (p_lz_neg) // [RULE12]
		else $error("inverted current result above zero");

	property p_bypass;
		sb.smp_vld && sb.bypass |=> sb.res == 16'($past(sb.smp));
	endproperty
	a_bypass: assert property (p_bypass) // [RULE15]
		else $error("torque bypass altered the sample");

	property p_bip_unity;
		sb.smp_vld && sb.kind == AIC_KIND_BIP && !sb.bypass
		&& sb.ofs == 11'h000 && sb.gain == `AIC_GAIN_RST
		|=> sb.res == ($past(sb.inv) ? -16'($past(sb.smp))
			: 16'($past(sb.smp)));
	endproperty
	a_bip_unity: assert property (p_bip_unity) // [RULE5]
		else $error("bipolar unity result wrong");
endmodule // aic_scale

// [rtl/aic_scl_if.sv]
// Interface between the controller and the scaling stage
`timescale 1ns/100ps
interface aic_scl_if import aic_pkg::*;;
	logic signed [11:0] smp;
	logic               smp_vld;
	logic signed [10:0] ofs;
	logic        [12:0] gain;
	aic_kind_e          kind;
	logic               inv;
	logic               bypass;
	logic signed [15:0] res;
	logic               res_vld;
	modport scaler (input smp, smp_vld, ofs, gain, kind, inv, bypass,
		output res, res_vld);
	modport ctrl (output smp, smp_vld, ofs, gain, kind, inv, bypass,
		input res, res_vld);
endinterface

// [rtl/aic_top.sv]
// Terminal strip analog input conditioning with register port
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "aic_cfg.svh"
module aic_top import aic_pkg::*; #(
	parameter int unsigned HIST_STEP_CYC = `AIC_HIST_STEP_MS * `AIC_CLK_KHZ
) (
	input  wire logic               CORE_CLK,
	input  wire logic               SRST,
	input  wire logic        [7:0]  ADDR,
	input  wire logic        [15:0] WR_DATA,
	input  wire logic               WR_STB,
	input  wire logic               RD_STB,
	output logic             [15:0] RD_DATA,
	input  wire logic signed [11:0] ADC_DATA,
	input  wire logic               ADC_VALID,
	output logic signed      [15:0] REF_OUT,
	output logic                    REF_VALID,
	output logic                    RUN_CMD,
	output logic                    LOSS_FAULT,
	output logic                    LOSS_ALARM,
	output logic                    IRQ
);
	logic signed [10:0]       ofs_reg;
	logic        [12:0]       gain_reg;
	aic_type_t                type_reg;
	logic signed [15:0]       preset_reg;
	logic        [1:0]        ctrl_reg;
	logic [`AIC_ST_W-1:0]     stat_reg;
	logic [`AIC_ST_W-1:0]     mask_reg;
	logic [`AIC_ST_W-1:0]     evt;
	logic [`AIC_ST_W-1:0]     clr;
	logic        [15:0]       rd_reg;
	logic signed [15:0]       wd;
	logic signed [15:0]       ofs_wr;
	logic        [15:0]       gain_wr;
	aic_kind_e                kind;
	logic                     inv;
	logic                     bad;
	logic                     loss_en;
	logic                     fault_t;
	logic                     hold_t;
	logic                     preset_t;
	logic                     t12;
	logic                     terminal_strip_source;
	logic                     torque;
	logic                     lost;
	logic                     loss_set;
	logic                     loss_clr;
	logic signed [15:0]       hist_reg [`AIC_HIST_DEPTH];
	logic        [2:0]        hist_idx;
	logic        [24:0]       tick_cnt;
	logic                     tick;
	logic signed [15:0]       hist_old;
	logic signed [15:0]       conv_reg;
	logic signed [15:0]       ref_sel;
	logic signed [15:0]       ref_reg;
	logic                     ref_vld_reg;
	logic                     alarm_reg;
	aic_run_e                 run_reg;
	aic_run_e                 run_next;

	aic_scl_if scl ();

	assign wd = signed'(WR_DATA);
	assign terminal_strip_source = ctrl_reg[`AIC_CTRL_SRC];
	assign torque = ctrl_reg[`AIC_CTRL_TRQ];

	// Offset and gain values are clipped to their legal ranges on write
	always_comb begin
		ofs_wr = wd;
		if (wd > `AIC_OFS_MAX) begin
			ofs_wr = `AIC_OFS_MAX; // [RULE1]
		end else if (wd < `AIC_OFS_MIN) begin
			ofs_wr = `AIC_OFS_MIN; // [RULE1]
		end
		gain_wr = WR_DATA;
		if (WR_DATA > `AIC_GAIN_MAX) begin
			gain_wr = `AIC_GAIN_MAX; // [RULE4]
		end else if (WR_DATA < `AIC_GAIN_MIN) begin
			gain_wr = `AIC_GAIN_MIN; // [RULE4]
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			ofs_reg    <= `AIC_OFS_RST; // [RULE1]
			gain_reg   <= `AIC_GAIN_RST; // [RULE4]
			type_reg   <= `AIC_TYPE_RST;
			preset_reg <= `AIC_PRESET_RST;
			ctrl_reg   <= 2'h0;
			mask_reg   <= '0;
		end else if (WR_STB) begin
			case (ADDR)
				`AIC_ADDR_OFS:    ofs_reg    <= ofs_wr[10:0];
				`AIC_ADDR_GAIN:   gain_reg   <= gain_wr[12:0];
				`AIC_ADDR_TYPE:   type_reg   <= WR_DATA[3:0];
				`AIC_ADDR_PRESET: preset_reg <= wd;
				`AIC_ADDR_CTRL:   ctrl_reg   <= WR_DATA[1:0];
				`AIC_ADDR_MASK:   mask_reg   <= WR_DATA[`AIC_ST_W-1:0];
				default: ;
			endcase
		end
	end

	// Input type decode
	always_comb begin
		kind     = AIC_KIND_BIP;
		inv      = type_reg[0];
		bad      = 1'b0;
		loss_en  = 1'b0;
		fault_t  = 1'b0;
		hold_t   = 1'b0;
		preset_t = 1'b0;
		t12      = 1'b0;
		case (type_reg)
			4'h0, 4'h1: kind = AIC_KIND_BIP; // [RULE5]
			4'h2, 4'h3, 4'h6, 4'h7: kind = AIC_KIND_UNI; // [RULE5] [RULE7]
			4'h4, 4'h5: begin
				kind    = AIC_KIND_LZ; // [RULE6]
				loss_en = 1'b1;
				fault_t = 1'b1;
			end
			4'h8, 4'h9: begin
				kind    = AIC_KIND_LZ; // [RULE8]
				loss_en = 1'b1;
				hold_t  = 1'b1;
			end
			4'ha, 4'hb: begin
				kind     = AIC_KIND_LZ; // [RULE9] [RULE14]
				loss_en  = 1'b1;
				preset_t = 1'b1;
			end
			4'hc: begin
				kind = AIC_KIND_UNI; // [RULE10]
				inv  = 1'b0;
				t12  = 1'b1;
			end
			default: begin
				inv = 1'b0;
				bad = 1'b1;
			end
		endcase
	end

	assign scl.smp     = ADC_DATA;
	assign scl.smp_vld = ADC_VALID;
	assign scl.ofs     = ofs_reg;
	assign scl.gain    = gain_reg;
	assign scl.kind    = kind;
	assign scl.inv     = inv;
	assign scl.bypass  = torque; // [RULE15]

	aic_scale u_scale (
		.clk  (CORE_CLK),
		.srst (SRST),
		.sb   (scl.scaler)
	);

	aic_loss u_loss (
		.clk       (CORE_CLK),
		.srst      (SRST),
		.smp       (ADC_DATA),
		.smp_vld   (ADC_VALID),
		.en        (loss_en),
		.lost      (lost),
		.lost_rise (loss_set),
		.lost_fall (loss_clr)
	);

	// Snapshots one step apart; the slot about to be overwritten is the
	// oldest, 4 to 5 steps old, and is frozen while the signal is lost
	assign tick     = tick_cnt == 25'(HIST_STEP_CYC - 1);
	assign hist_old = hist_reg[hist_idx];

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			tick_cnt <= 25'h0000000;
		end else if (tick) begin
			tick_cnt <= 25'h0000000;
		end else begin
			tick_cnt <= tick_cnt + 25'h0000001;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			hist_idx <= 3'h0;
			for (int i = 0; i < `AIC_HIST_DEPTH; i++) begin
				hist_reg[i] <= 16'h0000;
			end
		end else if (tick && !lost) begin
			hist_reg[hist_idx] <= conv_reg; // [RULE14]
			hist_idx <= (hist_idx == 3'(`AIC_HIST_DEPTH - 1)) ? 3'h0
				: hist_idx + 3'h1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			conv_reg <= 16'h0000;
		end else if (scl.res_vld && !lost) begin
			conv_reg <= scl.res;
		end
	end

	// Reference source on loss
	always_comb begin
		ref_sel = scl.res;
		if (bad) begin
			ref_sel = 16'h0000;
		end else if (lost && fault_t) begin
			ref_sel = 16'h0000; // [RULE6]
		end else if (lost && hold_t) begin
			ref_sel = hist_old; // [RULE8] [RULE14]
		end else if (lost && preset_t) begin
			ref_sel = type_reg[0] ? -preset_reg : preset_reg; // [RULE9]
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			ref_reg     <= 16'h0000;
			ref_vld_reg <= 1'b0;
			alarm_reg   <= 1'b0;
		end else begin
			ref_vld_reg <= scl.res_vld;
			alarm_reg   <= lost & (hold_t | preset_t); // [RULE8] [RULE13]
			if (scl.res_vld) begin
				ref_reg <= ref_sel;
			end
		end
	end

	// Start and stop from the input level, with hysteresis
	always_comb begin
		run_next = run_reg;
		if (!(t12 && terminal_strip_source)) begin
			run_next = AIC_RUN_IDLE; // [RULE10]
		end else if (scl.res_vld) begin
			case (run_reg)
				AIC_RUN_IDLE: if (scl.res >= `AIC_RUN_ON_TH) begin
					run_next = AIC_RUN_ON;
				end
				AIC_RUN_ON: if (scl.res < `AIC_RUN_OFF_TH) begin
					run_next = AIC_RUN_IDLE;
				end
				default: run_next = AIC_RUN_IDLE;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			run_reg <= AIC_RUN_IDLE;
		end else begin
			run_reg <= run_next;
		end
	end

	// Sticky status, a set in the clearing cycle wins
	always_comb begin
		evt = '0;
		evt[`AIC_ST_FAULT]   = loss_set & fault_t; // [RULE6]
		evt[`AIC_ST_ALM_SET] = loss_set & (hold_t | preset_t);
		evt[`AIC_ST_ALM_CLR] = loss_clr;
		evt[`AIC_ST_START]   = run_reg == AIC_RUN_IDLE
			&& run_next == AIC_RUN_ON;
		evt[`AIC_ST_STOP]    = run_reg == AIC_RUN_ON
			&& run_next == AIC_RUN_IDLE;
		evt[`AIC_ST_CFG_ERR] = bad | (t12 & ~terminal_strip_source);
		clr = (WR_STB && ADDR == `AIC_ADDR_STAT)
			? WR_DATA[`AIC_ST_W-1:0] : '0;
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			stat_reg <= '0;
		end else begin
			stat_reg <= (stat_reg & ~clr) | evt;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			rd_reg <= 16'h0000;
		end else if (RD_STB) begin
			case (ADDR)
				`AIC_ADDR_OFS:    rd_reg <= 16'(ofs_reg);
				`AIC_ADDR_GAIN:   rd_reg <= {3'h0, gain_reg};
				`AIC_ADDR_TYPE:   rd_reg <= {12'h000, type_reg};
				`AIC_ADDR_PRESET: rd_reg <= preset_reg;
				`AIC_ADDR_CTRL:   rd_reg <= {14'h0000, ctrl_reg};
				`AIC_ADDR_STAT:   rd_reg <= {10'h000, stat_reg};
				`AIC_ADDR_MASK:   rd_reg <= {10'h000, mask_reg};
				`AIC_ADDR_REF:    rd_reg <= ref_reg;
				`AIC_ADDR_LIVE:   rd_reg <= {12'h000, RUN_CMD, alarm_reg,
					lost, LOSS_FAULT};
				default:          rd_reg <= 16'h0000;
			endcase
		end else begin
			rd_reg <= 16'h0000;
		end
	end

	assign RD_DATA    = rd_reg;
	assign REF_OUT    = ref_reg;
	assign REF_VALID  = ref_vld_reg;
	assign RUN_CMD    = run_reg == AIC_RUN_ON;
	assign LOSS_FAULT = stat_reg[`AIC_ST_FAULT];
	assign LOSS_ALARM = alarm_reg;
	assign IRQ        = |(stat_reg & mask_reg);

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SRST);

	property p_ofs_range;
		16'(ofs_reg) >= `AIC_OFS_MIN && 16'(ofs_reg) <= `AIC_OFS_MAX;
	endproperty
	a_ofs_range: assert property (p_ofs_range) // [RULE1]
		else $error("offset outside -900..900");

	property p_gain_range;
		{3'h0, gain_reg} >= `AIC_GAIN_MIN && {3'h0, gain_reg} <= `AIC_GAIN_MAX;
	endproperty
	a_gain_range: assert property (p_gain_range) // [RULE4]
		else $error("gain outside 0.100..5.000");

	property p_fault;
		loss_set && fault_t |=> LOSS_FAULT && (IRQ || !mask_reg[0]);
	endproperty
	a_fault: assert property (p_fault) // [RULE6]
		else $error("loss on fault type did not fault");

	property p_hold;
		scl.res_vld && lost && hold_t |=> REF_OUT == $past(hist_old);
	endproperty
	a_hold: assert property (p_hold) // [RULE8]
		else $error("held reference not used");

	property p_preset;
		scl.res_vld && lost && type_reg == 4'ha
		|=> REF_OUT == $past(preset_reg) ##1 LOSS_ALARM || !lost;
	endproperty
	a_preset: assert property (p_preset) // [RULE9]
		else $error("preset speed not substituted");

	property p_preset_neg;
		scl.res_vld && lost && type_reg == 4'hb
		|=> REF_OUT == -$past(preset_reg);
	endproperty
	a_preset_neg: assert property (p_preset_neg) // [RULE14]
		else $error("negated preset not substituted");

	property p_run_src;
		!terminal_strip_source |=> !RUN_CMD;
	endproperty
	a_run_src: assert property (p_run_src) // [RULE10]
		else $error("run without strip control source");

	property p_run_start;
		t12 && terminal_strip_source && !RUN_CMD && scl.res_vld
		&& scl.res >= `AIC_RUN_ON_TH |=> RUN_CMD && stat_reg[`AIC_ST_START];
	endproperty
	a_run_start: assert property (p_run_start) // [RULE10]
		else $error("start threshold did not start");

	property p_alarm_clr;
		loss_clr |=> !LOSS_ALARM;
	endproperty
	a_alarm_clr: assert property (p_alarm_clr) // [RULE13]
		else $error("alarm stayed after input returned");
endmodule // aic_top

// [testbench/aic_src_model.sv]
// Behavioural analog source feeding converted samples to the block
`timescale 1ns/100ps
module aic_src_model (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic signed [11:0] lvl,
	input  wire logic        [3:0]  gap,
	output logic signed      [11:0] adc_data,
	output logic                    adc_valid
);
	logic [3:0] cnt_reg;

	// One sample every gap+1 cycles; a gap of zero holds the strobe high
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_reg <= 4'h0;
		end else begin
			cnt_reg <= (cnt_reg >= gap) ? 4'h0 : cnt_reg + 4'h1;
		end
	end

	// Between samples the data lines show the inverse, never a stale copy
	always_ff @(posedge clk) begin
		if (srst) begin
			adc_valid <= 1'b0;
			adc_data  <= 12'sh000;
		end else begin
			adc_valid <= (cnt_reg == 4'h0);
			adc_data  <= (cnt_reg == 4'h0) ? lvl : ~lvl;
		end
	end
endmodule // aic_src_model

// [testbench/analog_input_conditioning_tb.sv]
// Self-checking testbench of the analog input conditioning block
`timescale 1ns/100ps
`include "aic_cfg.svh"
module analog_input_conditioning_tb import aic_pkg::*;;
	logic               core_clk = 1'b0;
	logic               srst     = 1'b1;
	logic        [7:0]  addr     = 8'h00;
	logic        [15:0] wr_data  = 16'h0000;
	logic               wr_stb   = 1'b0;
	logic               rd_stb   = 1'b0;
	logic        [15:0] rd_data;
	logic signed [11:0] adc_data;
	logic               adc_valid;
	logic signed [11:0] lvl      = 12'sh000;
	logic        [3:0]  gap      = 4'h2;
	logic signed [15:0] ref_out;
	logic               ref_valid;
	logic               run_cmd;
	logic               loss_fault;
	logic               loss_alarm;
	logic               irq;
	logic        [15:0] d;
	int                 fails = 0;
	int                 check_count = 0;

	always #20 core_clk = ~core_clk;

	aic_top #(.HIST_STEP_CYC(8)) i_dut (
		.CORE_CLK(core_clk), .SRST(srst), .ADDR(addr), .WR_DATA(wr_data),
		.WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
		.ADC_DATA(adc_data), .ADC_VALID(adc_valid), .REF_OUT(ref_out),
		.REF_VALID(ref_valid), .RUN_CMD(run_cmd), .LOSS_FAULT(loss_fault),
		.LOSS_ALARM(loss_alarm), .IRQ(irq)
	);

	aic_src_model i_src (
		.clk(core_clk), .srst(srst), .lvl(lvl), .gap(gap),
		.adc_data(adc_data), .adc_valid(adc_valid)
	);

	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge core_clk);
		addr    <= a;
		wr_data <= v;
		wr_stb  <= 1'b1;
		@(posedge core_clk);
		wr_stb  <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge core_clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		#1 v = rd_data;
	endtask

	// Lets three fresh results through so outputs reflect the new setup
	task automatic settle();
		int n;
		n = 0;
		for (int i = 0; i < 100 && n < 3; i++) begin
			@(posedge core_clk);
			#1 if (ref_valid === 1'b1) n++;
		end
		chk("ref_valid_count", 16'(n), 16'h0003);
	endtask

	task automatic cfg(input int t, input int o, input int g, input int c);
		wr(`AIC_ADDR_TYPE, 16'(t));
		wr(`AIC_ADDR_OFS, 16'(o));
		wr(`AIC_ADDR_GAIN, 16'(g));
		wr(`AIC_ADDR_CTRL, 16'(c));
		settle();
	endtask

	function automatic logic [15:0] exp_ref(int t, int x, int o, int g);
		int s;
		s = (t >= 4 && t != 6 && t != 7) ? x - 200 + o : x + o;
		if (t >= 2 && s < 0) s = 0;
		s = s * g / 1000;
		return 16'(t[0] ? -s : s);
	endfunction

	task automatic t_reset_and_clamp();
		rd(`AIC_ADDR_OFS, d);   chk("ofs_rst", d, 16'h0000);
		rd(`AIC_ADDR_GAIN, d);  chk("gain_rst", d, 16'h03e8);
		rd(`AIC_ADDR_TYPE, d);  chk("type_rst", d, 16'h0000);
		rd(8'h24, d);           chk("unmapped", d, 16'h0000);
		wr(`AIC_ADDR_OFS, 16'd1000);
		rd(`AIC_ADDR_OFS, d);   chk("ofs_hi", d, 16'h0384);
		wr(`AIC_ADDR_OFS, -16'sd1000);
		rd(`AIC_ADDR_OFS, d);   chk("ofs_lo", d, 16'hfc7c);
		wr(`AIC_ADDR_GAIN, 16'd50);
		rd(`AIC_ADDR_GAIN, d);  chk("gain_lo", d, 16'h0064);
		wr(`AIC_ADDR_GAIN, 16'd6000);
		rd(`AIC_ADDR_GAIN, d);  chk("gain_hi", d, 16'h1388);
	endtask

	// Every type up to 11 under two offset and gain settings
	task automatic t_math();
		int xs[2] = '{500, 150};
		int os[2] = '{-100, -300};
		int gs[2] = '{1500, 2000};
		for (int k = 0; k < 2; k++) begin
			lvl <= 12'(xs[k]);
			for (int t = 0; t < 12; t++) begin
				cfg(t, os[k], gs[k], 0);
				chk("ref_math", ref_out, exp_ref(t, xs[k], os[k], gs[k]));
			end
		end
		cfg(1, 0, 1000, 0);
		chk("ref_unity", ref_out, exp_ref(1, 150, 0, 1000));
	endtask

	task automatic t_fault();
		wr(`AIC_ADDR_MASK, 16'h003f);
		rd(`AIC_ADDR_MASK, d);  chk("mask_rd", d, 16'h003f);
		cfg(4, 0, 1000, 0);
		lvl <= 12'sd50;
		settle();
		chk("fault", 16'(loss_fault), 16'h0001);
		chk("fault_ref", ref_out, 16'h0000);
		chk("irq_on", 16'(irq), 16'h0001);
		wr(`AIC_ADDR_MASK, 16'h0000);
		#1 chk("irq_masked", 16'(irq), 16'h0000);
		lvl <= 12'sd300;
		settle();
		wr(`AIC_ADDR_STAT, 16'h003f);
		rd(`AIC_ADDR_STAT, d);
		chk("fault_clr", {15'h0, d[0]}, 16'h0000);
		chk("fault_pin", 16'(loss_fault), 16'h0000);
	endtask

	task automatic t_preset();
		wr(`AIC_ADDR_PRESET, 16'h0123);
		rd(`AIC_ADDR_PRESET, d);  chk("preset_rd", d, 16'h0123);
		for (int t = 10; t < 12; t++) begin
			cfg(t, 0, 1000, 0);
			wr(`AIC_ADDR_STAT, 16'h003f);
			lvl <= 12'sd50;
			settle();
			chk("alarm", 16'(loss_alarm), 16'h0001);
			chk("preset_ref", ref_out, (t == 10) ? 16'h0123 : 16'hfedd);
			rd(`AIC_ADDR_REF, d);
			chk("ref_reg", d, (t == 10) ? 16'h0123 : 16'hfedd);
			rd(`AIC_ADDR_LIVE, d);  chk("live", d, 16'h0006);
			rd(`AIC_ADDR_STAT, d);
			chk("alm_set", d & 16'h0007, 16'h0002);
			lvl <= 12'sd150;
			settle();
			chk("alarm_hyst", 16'(loss_alarm), 16'h0001);
			lvl <= 12'sd200;
			settle();
			chk("alarm_end", 16'(loss_alarm), 16'h0000);
			chk("ref_back", ref_out, 16'h0000);
			rd(`AIC_ADDR_STAT, d);
			chk("alm_clr", d & 16'h0004, 16'h0004);
		end
	endtask

	task automatic t_hold();
		lvl <= 12'sd400;
		cfg(8, 0, 1000, 0);
		repeat (80) @(posedge core_clk);
		lvl <= 12'sd300;
		repeat (12) @(posedge core_clk);
		lvl <= 12'sd50;
		settle();
		chk("hold_alarm", 16'(loss_alarm), 16'h0001);
		chk("hold_ref", ref_out, 16'h00c8);
		lvl <= 12'sd300;
		settle();
	endtask

	task automatic t_run();
		cfg(12, 0, 1000, 1);
		lvl <= 12'sd150;
		settle();
		chk("run_on", 16'(run_cmd), 16'h0001);
		lvl <= 12'sd80;
		settle();
		chk("run_hold", 16'(run_cmd), 16'h0001);
		lvl <= 12'sd40;
		settle();
		chk("run_off", 16'(run_cmd), 16'h0000);
		rd(`AIC_ADDR_STAT, d);
		chk("start_stop", d & 16'h0018, 16'h0018);
		lvl <= 12'sd150;
		cfg(12, 0, 1000, 0);
		chk("run_nosrc", 16'(run_cmd), 16'h0000);
		wr(`AIC_ADDR_STAT, 16'h003f);
		rd(`AIC_ADDR_STAT, d);
		chk("cfg_err", d & 16'h0020, 16'h0020);
		cfg(13, 0, 1000, 0);
		chk("bad_type_ref", ref_out, 16'h0000);
	endtask

	task automatic t_torque();
		gap <= 4'h0;
		lvl <= 12'sd300;
		cfg(4, 100, 3000, 2);
		chk("trq_ref", ref_out, 16'h012c);
		rd(`AIC_ADDR_CTRL, d);  chk("ctrl_rd", d, 16'h0002);
		lvl <= 12'sd50;
		settle();
		chk("trq_loss", 16'(loss_fault), 16'h0001);
	endtask

	task automatic give_verdict();
		if (fails == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		t_reset_and_clamp();
		t_math();
		t_fault();
		t_preset();
		t_hold();
		t_run();
		t_torque();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		give_verdict();
	end
endmodule // analog_input_conditioning_tb
